// ### core/avgc_core.sv
// Per-axis velocity command, adjustment and gearing role logic
//
// Contract
// - Servo velocity means encoder counts per 341 us sample, 16 fraction bits.
// - Each axis velocity command is stored as a 32-bit word.
// - Servo velocity is limited to 0 through 16,777,215.
// - Servo axes hold velocity 32,768 after power-up.
// - Stepper velocity is peak or constant speed in steps per second.
// - Stepper velocity limited to 1 through 1,048,575; power-up value 3.
// - Out-of-range values saturate to nearest limit, no error raised.
// - Position mode uses active velocity as trapezoid peak speed.
// - Velocity mode runs at last activated speed until start or stop.
// - New velocity waits in pending buffer, overwritten until start or stop.
// - Stepper adjustment is signed 16-bit, saturated to plus/minus 20,000.
// - Adjustment ignored unless axis is in constant-velocity motion.
// - Applied adjustment adds to target velocity at once, no ramp.
// - A new adjustment replaces the previous one.
// - Adjustment clears when the move completes or is stopped.
// - Servo role code: 0 normal, 00FF slave, FF00 reverse slave, FFFF master.
// - Only one master per board; the latest designation wins.
// - Reverse slave runs opposite the master, normal slave the same way.
// - Velocity mode on a slave is refused with a command error.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module avgc_core #(
  parameter int SAMPLE_CYCLES = avgc_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Board variant strap, high on stepper boards
  input wire logic variant_stepper,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Trajectory generator status
  input wire avgc_pkg::avgc_phase_e [avgc_pkg::NUM_AXES-1:0] axis_phase,
  input wire logic [avgc_pkg::NUM_AXES-1:0] move_done,
  // Velocity and role towards trajectory and following loop
  output avgc_pkg::avgc_axis_out_s [avgc_pkg::NUM_AXES-1:0] axis_out,
  output logic [avgc_pkg::NUM_AXES-1:0] start_pulse,
  output logic [avgc_pkg::NUM_AXES-1:0] stop_pulse,
  output logic sample_tick,
  output logic cmd_error
);

  localparam logic [16:0] SAMPLE_LAST = 17'(SAMPLE_CYCLES - 1);

  avgc_pkg::avgc_state_s s_r;
  avgc_pkg::avgc_state_s s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Saturation helpers

  function automatic logic [31:0] clamp_vel(input logic [31:0] v, input logic stp);
    logic [31:0] r;
    r = v;
    if (stp)
    begin
      if (v < avgc_pkg::STEP_VEL_MIN)
        r = avgc_pkg::STEP_VEL_MIN;
      else if (v > avgc_pkg::STEP_VEL_MAX)
        r = avgc_pkg::STEP_VEL_MAX;
    end
    else if (v > avgc_pkg::SERVO_VEL_MAX)
      r = avgc_pkg::SERVO_VEL_MAX;
    return r;
  endfunction

  function automatic logic signed [15:0] clamp_adj(input logic [31:0] w);
    logic signed [15:0] a;
    a = $signed(w[15:0]);
    if (a > avgc_pkg::ADJ_MAX)
      a = avgc_pkg::ADJ_MAX;
    else if (a < avgc_pkg::ADJ_MIN)
      a = avgc_pkg::ADJ_MIN;
    return a;
  endfunction

  function automatic logic [31:0] sum_vel(input logic [31:0] v, input logic signed [15:0] a);
    logic signed [33:0] t;
    logic [31:0] r;
    t = $signed({2'b00, v}) + 34'(a);
    if (t < $signed({2'b00, avgc_pkg::STEP_VEL_MIN}))
      r = avgc_pkg::STEP_VEL_MIN;
    else if (t > $signed({2'b00, avgc_pkg::STEP_VEL_MAX}))
      r = avgc_pkg::STEP_VEL_MAX;
    else
      r = t[31:0];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    logic ax_hit;
    logic [1:0] wa;
    logic [1:0] wr_reg;
    logic [avgc_pkg::NUM_AXES-1:0] go;
    logic [avgc_pkg::NUM_AXES-1:0] halt;
    logic role_ok;
    avgc_pkg::avgc_role_e new_role;
    ax_hit = 1'b0;
    wa = 2'h0;
    wr_reg = 2'h0;
    go = '0;
    halt = '0;
    role_ok = 1'b0;
    new_role = avgc_pkg::ROLE_NORMAL;
    s_nxt = s_r;
    s_nxt.start = '0;
    s_nxt.stop = '0;
    s_nxt.rdata = 32'h0000_0000;

    // Servo sample-period enable
    if (s_r.sample_cnt == SAMPLE_LAST)
    begin
      s_nxt.sample_cnt = '0;
      s_nxt.sample_tick = ~s_r.stepper;
    end
    else
    begin
      s_nxt.sample_cnt = s_r.sample_cnt + 17'h00001;
      s_nxt.sample_tick = 1'b0;
    end

    ax_hit = (reg_addr & avgc_pkg::AXIS_WIN_MASK) == avgc_pkg::AXIS_WIN_BASE;
    wa = reg_addr[5:4];
    wr_reg = reg_addr[3:2];

    case (reg_wdata[15:0])
      avgc_pkg::ROLE_CODE_NORMAL:
      begin
        role_ok = 1'b1;
        new_role = avgc_pkg::ROLE_NORMAL;
      end
      avgc_pkg::ROLE_CODE_SLAVE:
      begin
        role_ok = 1'b1;
        new_role = avgc_pkg::ROLE_SLAVE;
      end
      avgc_pkg::ROLE_CODE_REV:
      begin
        role_ok = 1'b1;
        new_role = avgc_pkg::ROLE_REV;
      end
      avgc_pkg::ROLE_CODE_MASTER:
      begin
        role_ok = 1'b1;
        new_role = avgc_pkg::ROLE_MASTER;
      end
      default:
      begin
        role_ok = 1'b0;
        new_role = avgc_pkg::ROLE_NORMAL;
      end
    endcase

    if (reg_wr && reg_addr == avgc_pkg::REG_CMD)
    begin
      go = reg_wdata[avgc_pkg::NUM_AXES-1:0];
      halt = reg_wdata[avgc_pkg::CMD_STOP_LSB +: avgc_pkg::NUM_AXES];
    end
    if (reg_wr && reg_addr == avgc_pkg::REG_STATUS && reg_wdata[avgc_pkg::STAT_ERR_BIT])
      s_nxt.cmd_err = 1'b0;

    // Register writes change the addressed axis, except that a new master demotes any other master axis to normal
    if (reg_wr && ax_hit)
    begin
      unique case (wr_reg)
        avgc_pkg::AX_REG_PEND:
          s_nxt.ax[wa].pend_vel = clamp_vel(reg_wdata, s_r.stepper);
        avgc_pkg::AX_REG_ADJ:
        begin
          if (s_r.stepper && axis_phase[wa] == avgc_pkg::PH_CONST)
            s_nxt.ax[wa].adj = clamp_adj(reg_wdata);
        end
        avgc_pkg::AX_REG_ROLE:
        begin
          if (!s_r.stepper && role_ok)
          begin
            s_nxt.ax[wa].role = new_role;
            if (new_role == avgc_pkg::ROLE_MASTER)
            begin
              for (int j = 0; j < avgc_pkg::NUM_AXES; j++)
              begin
                if (2'(j) != wa && s_r.ax[j].role == avgc_pkg::ROLE_MASTER)
                  s_nxt.ax[j].role = avgc_pkg::ROLE_NORMAL;
              end
            end
            if (new_role == avgc_pkg::ROLE_SLAVE || new_role == avgc_pkg::ROLE_REV)
              s_nxt.ax[wa].vel_mode = 1'b0;
          end
          else
            s_nxt.cmd_err = 1'b1;
        end
        avgc_pkg::AX_REG_ACT:
        begin
        end
      endcase
    end

    // Mode, start, stop and move completion per axis
    for (int i = 0; i < avgc_pkg::NUM_AXES; i++)
    begin
      if (reg_wr && reg_addr == avgc_pkg::REG_MODE)
      begin
        if (reg_wdata[i] && (s_r.ax[i].role == avgc_pkg::ROLE_SLAVE || s_r.ax[i].role == avgc_pkg::ROLE_REV))
          s_nxt.cmd_err = 1'b1;
        else
          s_nxt.ax[i].vel_mode = reg_wdata[i];
      end
      if (go[i] || halt[i])
        s_nxt.ax[i].act_vel = s_r.ax[i].pend_vel;
      if (go[i] || halt[i] || move_done[i])
        s_nxt.ax[i].adj = 16'sh0000;
      s_nxt.start[i] = go[i];
      s_nxt.stop[i] = halt[i];
      s_nxt.out[i].act_vel = s_nxt.ax[i].act_vel;
      if (s_r.stepper)
        s_nxt.out[i].cmd_vel = sum_vel(s_nxt.ax[i].act_vel, s_nxt.ax[i].adj);
      else
        s_nxt.out[i].cmd_vel = s_nxt.ax[i].act_vel;
      s_nxt.out[i].role = s_nxt.ax[i].role;
      s_nxt.out[i].vel_mode = s_nxt.ax[i].vel_mode;
      s_nxt.out[i].reverse = s_nxt.ax[i].role == avgc_pkg::ROLE_REV;
    end

    // Read data, one cycle after the strobe
    if (reg_rd)
    begin
      if (ax_hit)
      begin
        unique case (wr_reg)
          avgc_pkg::AX_REG_PEND:
            s_nxt.rdata = s_r.ax[wa].pend_vel;
          avgc_pkg::AX_REG_ACT:
            s_nxt.rdata = s_r.ax[wa].act_vel;
          avgc_pkg::AX_REG_ADJ:
            s_nxt.rdata = 32'(s_r.ax[wa].adj);
          avgc_pkg::AX_REG_ROLE:
          begin
            unique case (s_r.ax[wa].role)
              avgc_pkg::ROLE_NORMAL:
                s_nxt.rdata = {16'h0000, avgc_pkg::ROLE_CODE_NORMAL};
              avgc_pkg::ROLE_SLAVE:
                s_nxt.rdata = {16'h0000, avgc_pkg::ROLE_CODE_SLAVE};
              avgc_pkg::ROLE_REV:
                s_nxt.rdata = {16'h0000, avgc_pkg::ROLE_CODE_REV};
              avgc_pkg::ROLE_MASTER:
                s_nxt.rdata = {16'h0000, avgc_pkg::ROLE_CODE_MASTER};
            endcase
          end
        endcase
      end
      else if (reg_addr == avgc_pkg::REG_MODE)
      begin
        for (int k = 0; k < avgc_pkg::NUM_AXES; k++)
          s_nxt.rdata[k] = s_r.ax[k].vel_mode;
      end
      else if (reg_addr == avgc_pkg::REG_STATUS)
      begin
        s_nxt.rdata[avgc_pkg::STAT_ERR_BIT] = s_r.cmd_err;
        s_nxt.rdata[avgc_pkg::STAT_STEP_BIT] = s_r.stepper;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      s_r <= '0;
      s_r.stepper <= variant_stepper;
      for (int i = 0; i < avgc_pkg::NUM_AXES; i++)
      begin
        s_r.ax[i].pend_vel <= variant_stepper ? avgc_pkg::STEP_VEL_DEF : avgc_pkg::SERVO_VEL_DEF;
        s_r.ax[i].act_vel <= variant_stepper ? avgc_pkg::STEP_VEL_DEF : avgc_pkg::SERVO_VEL_DEF;
        s_r.out[i].act_vel <= variant_stepper ? avgc_pkg::STEP_VEL_DEF : avgc_pkg::SERVO_VEL_DEF;
        s_r.out[i].cmd_vel <= variant_stepper ? avgc_pkg::STEP_VEL_DEF : avgc_pkg::SERVO_VEL_DEF;
      end
    end
    else
      s_r <= s_nxt;
  end

  assign reg_rdata = s_r.rdata;
  assign axis_out = s_r.out;
  assign start_pulse = s_r.start;
  assign stop_pulse = s_r.stop;
  assign sample_tick = s_r.sample_tick;
  assign cmd_error = s_r.cmd_err;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  one_master_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $onehot0({s_r.ax[3].role == avgc_pkg::ROLE_MASTER, s_r.ax[2].role == avgc_pkg::ROLE_MASTER,
              s_r.ax[1].role == avgc_pkg::ROLE_MASTER, s_r.ax[0].role == avgc_pkg::ROLE_MASTER}))
    else $error("more than one master axis");

  reset_default_a: assert property (@(posedge ref_clk)
    !reset_n ##1 reset_n && !s_r.stepper |-> s_r.ax[0].act_vel == 32'h0000_8000)
    else $error("servo power-up velocity wrong");

  generate
    for (genvar g = 0; g < avgc_pkg::NUM_AXES; g++)
    begin : g_chk
      servo_clamp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr && reg_addr == 8'(g * 16) && !s_r.stepper && reg_wdata > 32'h00FF_FFFF
        |=> s_r.ax[g].pend_vel == 32'h00FF_FFFF)
        else $error("servo velocity not saturated");
      step_floor_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr && reg_addr == 8'(g * 16) && s_r.stepper && reg_wdata == 32'h0000_0000
        |=> s_r.ax[g].pend_vel == 32'h0000_0001)
        else $error("stepper velocity floor wrong");
      pend_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr && reg_addr == 8'(g * 16) |=> $stable(s_r.ax[g].act_vel) && $stable(axis_out[g].act_vel))
        else $error("pending write disturbed motion");
      start_commit_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr && reg_addr == 8'h44 && reg_wdata[g] |=> s_r.ax[g].act_vel == $past(s_r.ax[g].pend_vel)
        && start_pulse[g] ##1 (!start_pulse[g] || $past(reg_wr && reg_addr == 8'h44 && reg_wdata[g])))
        else $error("start did not activate pending velocity");
      adj_ignore_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr && reg_addr == 8'(g * 16 + 8) && axis_phase[g] != avgc_pkg::PH_CONST && !move_done[g]
        |=> $stable(s_r.ax[g].adj))
        else $error("adjustment taken outside constant velocity");
      adj_clamp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr && reg_addr == 8'(g * 16 + 8) && axis_phase[g] == avgc_pkg::PH_CONST && s_r.stepper
        && !move_done[g] && $signed(reg_wdata[15:0]) > 16'sh4E20 |=> s_r.ax[g].adj == 16'sh4E20)
        else $error("adjustment not saturated");
      adj_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        move_done[g] |=> s_r.ax[g].adj == 16'sh0000)
        else $error("adjustment survived move end");
      slave_pos_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_r.ax[g].role == avgc_pkg::ROLE_SLAVE || s_r.ax[g].role == avgc_pkg::ROLE_REV |-> !s_r.ax[g].vel_mode)
        else $error("slave axis in velocity mode");
      reverse_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $changed(s_r.ax[g].role) |-> axis_out[g].reverse == (s_r.ax[g].role == avgc_pkg::ROLE_REV))
        else $error("reverse flag does not follow role");
    end
  endgenerate

endmodule // avgc_core

`default_nettype wire

// ### include/avgc_pkg.sv
// Constants, types and state layout of the axis velocity and gearing block
package avgc_pkg;

  localparam int NUM_AXES = 4;
  localparam int VEL_W = 32;
  localparam int ADJ_W = 16;

  // Velocity limits and power-up defaults
  localparam logic [31:0] SERVO_VEL_MIN = 32'h0000_0000;
  localparam logic [31:0] SERVO_VEL_MAX = 32'h00FF_FFFF;
  localparam logic [31:0] SERVO_VEL_DEF = 32'h0000_8000;
  localparam logic [31:0] STEP_VEL_MIN = 32'h0000_0001;
  localparam logic [31:0] STEP_VEL_MAX = 32'h000F_FFFF;
  localparam logic [31:0] STEP_VEL_DEF = 32'h0000_0003;
  localparam logic signed [15:0] ADJ_MAX = 16'sh4E20;
  localparam logic signed [15:0] ADJ_MIN = -16'sh4E20;
  localparam int FRAC_BITS = 16;

  // Servo sample period
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SAMPLE_PERIOD_NS = 341000;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int SAMPLE_CNT_W = 17;

  // Role codes
  localparam logic [15:0] ROLE_CODE_NORMAL = 16'h0000;
  localparam logic [15:0] ROLE_CODE_SLAVE = 16'h00FF;
  localparam logic [15:0] ROLE_CODE_REV = 16'hFF00;
  localparam logic [15:0] ROLE_CODE_MASTER = 16'hFFFF;

  // Register map: per-axis window, axis in address bits 5:4
  localparam logic [7:0] AXIS_WIN_MASK = 8'hC0;
  localparam logic [7:0] AXIS_WIN_BASE = 8'h00;
  localparam logic [1:0] AX_REG_PEND = 2'h0;
  localparam logic [1:0] AX_REG_ACT = 2'h1;
  localparam logic [1:0] AX_REG_ADJ = 2'h2;
  localparam logic [1:0] AX_REG_ROLE = 2'h3;
  localparam logic [7:0] REG_MODE = 8'h40;
  localparam logic [7:0] REG_CMD = 8'h44;
  localparam logic [7:0] REG_STATUS = 8'h48;
  localparam int CMD_STOP_LSB = 4;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_STEP_BIT = 1;

  typedef enum logic [1:0] {
    ROLE_NORMAL = 2'b00,
    ROLE_SLAVE = 2'b01,
    ROLE_REV = 2'b10,
    ROLE_MASTER = 2'b11
  } avgc_role_e;

  typedef enum logic [1:0] {
    PH_STOPPED = 2'b00,
    PH_ACCEL = 2'b01,
    PH_CONST = 2'b10,
    PH_DECEL = 2'b11
  } avgc_phase_e;

  typedef struct packed {
    logic [31:0] pend_vel;
    logic [31:0] act_vel;
    logic signed [15:0] adj;
    avgc_role_e role;
    logic vel_mode;
  } avgc_axis_s;

  typedef struct packed {
    logic [31:0] cmd_vel;
    logic [31:0] act_vel;
    avgc_role_e role;
    logic vel_mode;
    logic reverse;
  } avgc_axis_out_s;

  typedef struct packed {
    avgc_axis_s [NUM_AXES-1:0] ax;
    avgc_axis_out_s [NUM_AXES-1:0] out;
    logic [NUM_AXES-1:0] start;
    logic [NUM_AXES-1:0] stop;
    logic stepper;
    logic cmd_err;
    logic [SAMPLE_CNT_W-1:0] sample_cnt;
    logic sample_tick;
    logic [31:0] rdata;
  } avgc_state_s;

endpackage

// ### verif/test_axis_velocity_and_gearing_cfg.sv
// Self-checking bench for the axis velocity and gearing block
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_axis_velocity_and_gearing_cfg;
  logic ref_clk;
  logic reset_n;
  logic variant_stepper;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  avgc_pkg::avgc_phase_e [3:0] axis_phase;
  logic [3:0] move_done;
  avgc_pkg::avgc_axis_out_s [3:0] axis_out;
  logic [3:0] start_pulse;
  logic [3:0] stop_pulse;
  logic sample_tick;
  logic cmd_error;
  int n_errors;
  int checked;
  int cyc;
  int ticks;
  // Behavioural model
  int pend[4];
  int act[4];
  int adj[4];
  int role[4];
  int vm[4];
  bit err;
  bit stp;

  avgc_core #(.SAMPLE_CYCLES(8)) avgc_core_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .variant_stepper(variant_stepper),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .axis_phase(axis_phase), .move_done(move_done), .axis_out(axis_out),
    .start_pulse(start_pulse), .stop_pulse(stop_pulse), .sample_tick(sample_tick), .cmd_error(cmd_error)
  );

  ////////////////////////////////////////////////////////////////////////////
  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cyc++;
    if (sample_tick !== 1'b0)
      ticks++;
    if (cyc == 6000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ad(input int x, input int r);
    return 8'(x * 16 + r * 4);
  endfunction

  function automatic logic [15:0] code(input int i);
    case (i)
      0: return avgc_pkg::ROLE_CODE_NORMAL;
      1: return avgc_pkg::ROLE_CODE_SLAVE;
      2: return avgc_pkg::ROLE_CODE_REV;
      default: return avgc_pkg::ROLE_CODE_MASTER;
    endcase
  endfunction

  function automatic logic [31:0] clampv(input logic [31:0] d);
    logic [31:0] mn;
    logic [31:0] mx;
    mn = stp ? avgc_pkg::STEP_VEL_MIN : avgc_pkg::SERVO_VEL_MIN;
    mx = stp ? avgc_pkg::STEP_VEL_MAX : avgc_pkg::SERVO_VEL_MAX;
    return (d > mx) ? mx : ((d < mn) ? mn : d);
  endfunction

  function automatic logic [31:0] mexp(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a < avgc_pkg::REG_MODE)
      case (a[3:2])
        2'h0: v = 32'(pend[a[5:4]]);
        2'h1: v = 32'(act[a[5:4]]);
        2'h2: v = 32'(adj[a[5:4]]);
        default: v = {16'h0000, code(role[a[5:4]])};
      endcase
    else if (a == avgc_pkg::REG_MODE)
      for (int j = 0; j < 4; j++)
        v[j] = 1'(vm[j]);
    else if (a == avgc_pkg::REG_STATUS)
      v = {30'h0000_0000, stp, err};
    return v;
  endfunction

  task automatic mwr(input logic [7:0] a, input logic [31:0] d);
    int x;
    int r;
    int k;
    x = a[5:4];
    r = -1;
    if (a < avgc_pkg::REG_MODE)
      case (a[3:2])
        2'h0: pend[x] = clampv(d);
        2'h2: if (stp && axis_phase[x] == avgc_pkg::PH_CONST)
        begin
          k = $signed(d[15:0]);
          adj[x] = (k > 20000) ? 20000 : ((k < -20000) ? -20000 : k);
        end
        2'h3:
        begin
          for (int i = 0; i < 4; i++)
            if (d[15:0] == code(i))
              r = i;
          if (stp || r < 0)
            err = 1;
          else
          begin
            for (int j = 0; j < 4; j++)
              if (r == 3 && role[j] == 3)
                role[j] = 0;
            role[x] = r;
            if (r == 1 || r == 2)
              vm[x] = 0;
          end
        end
        default: ;
      endcase
    else if (a == avgc_pkg::REG_MODE)
      for (int j = 0; j < 4; j++)
        if (d[j] && (role[j] == 1 || role[j] == 2))
          err = 1;
        else
          vm[j] = d[j];
    else if (a == avgc_pkg::REG_CMD)
    begin
      for (int j = 0; j < 4; j++)
        if (d[j] || d[j + 4])
        begin
          act[j] = pend[j];
          adj[j] = 0;
        end
    end
    else if (a == avgc_pkg::REG_STATUS && d[0])
      err = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
    mwr(a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, mexp(a))
    @(posedge ref_clk);
    #1;
    `CHK(reg_rdata, 32'h0000_0000)
  endtask

  task automatic chk_out();
    longint v;
    for (int j = 0; j < 4; j++)
    begin
      v = act[j] + adj[j];
      v = stp ? ((v > 1048575) ? 1048575 : ((v < 1) ? 1 : v)) : act[j];
      `CHK(axis_out[j].act_vel, 32'(act[j]))
      `CHK(axis_out[j].cmd_vel, 32'(v))
      `CHK(axis_out[j].role, 2'(role[j]))
      `CHK(axis_out[j].reverse, 1'(role[j] == 2))
      `CHK(axis_out[j].vel_mode, 1'(vm[j]))
    end
    `CHK(cmd_error, err)
  endtask

  task automatic do_reset(input bit s);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    variant_stepper <= s;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    stp = s;
    err = 0;
    for (int j = 0; j < 4; j++)
    begin
      pend[j] = s ? 3 : 32768;
      act[j] = pend[j];
      adj[j] = 0;
      role[j] = 0;
      vm[j] = 0;
    end
    #1;
    chk_out();
    for (int j = 0; j < 4; j++)
    begin
      rd(ad(j, 0));
      rd(ad(j, 1));
    end
  endtask

  task automatic count_ticks(input int n);
    @(posedge ref_clk);
    #1;
    ticks = 0;
    repeat (80) @(posedge ref_clk);
    #1;
    `CHK(ticks, n)
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 0;
    reset_n = 0;
    variant_stepper = 0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 0;
    reg_rd = 0;
    move_done = 4'h0;
    for (int j = 0; j < 4; j++)
      axis_phase[j] = avgc_pkg::PH_STOPPED;
    void'($urandom(77305));
    do_reset(0);
    for (int i = 0; i < 10; i++)
    begin
      wr(ad($urandom_range(3), 0), $urandom >> $urandom_range(16));
      chk_out();
      rd(ad(i % 4, 0));
    end
    wr(ad(1, 0), 32'hFFFF_FFFF);
    rd(ad(1, 0));
    wr(ad(1, 0), 32'h0012_3400);
    wr(avgc_pkg::REG_CMD, 32'h0000_0002);
    `CHK(start_pulse, 4'h2)
    chk_out();
    rd(ad(1, 1));
    wr(ad(1, 1), 32'h0000_0055);
    rd(ad(1, 1));
    wr(ad(2, 0), 32'h0000_0000);
    wr(avgc_pkg::REG_MODE, 32'h0000_000F);
    wr(avgc_pkg::REG_CMD, 32'h0000_0040);
    `CHK(stop_pulse, 4'h4)
    chk_out();
    rd(avgc_pkg::REG_MODE);
    for (int i = 0; i < 5; i++)
    begin
      wr(ad(2, 3), (i == 4) ? 32'h0000_1234 : {16'h0000, code(i)});
      rd(ad(2, 3));
      chk_out();
    end
    wr(avgc_pkg::REG_STATUS, 32'h0000_0001);
    wr(ad(0, 3), 32'h0000_FFFF);
    wr(ad(3, 3), 32'h0000_FFFF);
    chk_out();
    wr(ad(1, 3), 32'h0000_FF00);
    wr(avgc_pkg::REG_MODE, 32'h0000_0003);
    chk_out();
    rd(avgc_pkg::REG_STATUS);
    wr(avgc_pkg::REG_STATUS, 32'h0000_0001);
    @(posedge ref_clk);
    axis_phase[0] <= avgc_pkg::PH_CONST;
    wr(ad(0, 2), 32'h0000_0100);
    rd(ad(0, 2));
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80);
    rd(8'h4C);
    rd(avgc_pkg::REG_CMD);
    count_ticks(10);
    do_reset(1);
    rd(avgc_pkg::REG_STATUS);
    count_ticks(0);
    wr(ad(0, 0), 32'h0000_0000);
    rd(ad(0, 0));
    wr(ad(0, 0), 32'h8000_0000);
    rd(ad(0, 0));
    wr(ad(0, 0), 32'h0000_7530);
    wr(avgc_pkg::REG_CMD, 32'h0000_0001);
    @(posedge ref_clk);
    axis_phase[0] <= avgc_pkg::PH_ACCEL;
    wr(ad(0, 2), 32'h0000_0064);
    rd(ad(0, 2));
    @(posedge ref_clk);
    axis_phase[0] <= avgc_pkg::PH_CONST;
    wr(ad(0, 2), 32'h0000_7530);
    chk_out();
    rd(ad(0, 2));
    wr(ad(0, 2), 32'h0000_8000);
    chk_out();
    wr(ad(0, 2), 32'h0000_FFFB);
    chk_out();
    @(posedge ref_clk);
    move_done <= 4'h1;
    @(posedge ref_clk);
    move_done <= 4'h0;
    #1;
    adj[0] = 0;
    chk_out();
    wr(ad(0, 2), 32'h0000_0007);
    wr(avgc_pkg::REG_CMD, 32'h0000_0010);
    `CHK(stop_pulse, 4'h1)
    chk_out();
    wr(ad(2, 3), 32'h0000_00FF);
    chk_out();
    wrap_up();
  end
endmodule // test_axis_velocity_and_gearing_cfg

`default_nettype wire
